// ---- bprs_pkg.sv ----
package bprs_pkg;
    // Oscillator rate in kHz; all timing derives from it
    localparam int unsigned CLK_KHZ = 1800;
    // Debounce settle time in microseconds
    localparam int unsigned DEBOUNCE_US = 10000;
    localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * CLK_KHZ) / 1000;
    // Board reset pulse length in microseconds
    localparam int unsigned RESET_PULSE_US = 100;
    localparam int unsigned RESET_PULSE_CYC = ((RESET_PULSE_US * CLK_KHZ) + 999) / 1000;
    // Time allowed for one rail to report good, microseconds
    localparam int unsigned RAIL_WAIT_US = 50000;
    localparam int unsigned RAIL_WAIT_CYC = (RAIL_WAIT_US * CLK_KHZ) / 1000;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned SITE_SEL_XMC = 1;

    typedef enum {
        BPRS_ST_OFF,
        BPRS_ST_RAMP,
        BPRS_ST_RESET,
        BPRS_ST_RUN,
        BPRS_ST_FAULT
    } bprs_state_t;

    // Processor-facing interrupt outputs, active low
    typedef struct packed {
        logic timer_abort_irq_n;
        logic board_temp_irq_n;
        logic rtc_irq_n;
    } bprs_irq_t;
endpackage

// ---- bprs_rails.sv ----
`timescale 1ns/100ps
`default_nettype none
module bprs_rails (
    input wire logic clk_sys_i,
    input wire logic hold_i,
    input wire logic [3:0] fail_i,
    input wire logic [3:0] rail_en_i,
    output logic [3:0] rail_pgood_o
);
    // Good follows enable a cycle late; hold stalls rises, fail forces low unless held
    always_ff @(posedge clk_sys_i) begin
        rail_pgood_o <= hold_i ? rail_pgood_o & rail_en_i : rail_en_i & ~fail_i;
    end
endmodule
`default_nettype wire

// ---- bprs_sequencer.sv ----
// Functional notes
// - Separate enable and power-good per regulator
// - Any rail failure drops all enables
// - Fault latches off; the power-arrival reset does not clear it
// - Board reset held until power-up completes
// - Front, rear switch, processor request reset
// - Everything runs from one oscillator clock
// - Presence selects each site's PCIe mux
// - Timers and abort share one interrupt
// - Temperature alert passed to own interrupt
// - Clock-chip interrupt passed to own output
// - Watchdog reset after failed boot swaps flash
// - Power-up boot flash from switch only
`timescale 1ns/100ps
`default_nettype none
module bprs_sequencer
    import bprs_pkg::*;
#(
    parameter int unsigned N_RAILS = 4,
    parameter int unsigned N_SITES = 2,
    parameter int unsigned N_TIMERS = 4,
    parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int unsigned RAIL_WAIT_CYCLES = RAIL_WAIT_CYC,
    parameter int unsigned RESET_CYCLES = RESET_PULSE_CYC
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [N_RAILS-1:0] rail_pgood_i,
    input wire logic front_reset_sw_n_i,
    input wire logic rear_reset_sw_n_i,
    input wire logic cpu_reset_req_i,
    input wire logic watchdog_reset_i,
    input wire logic boot_ok_i,
    input wire logic boot_select_switch_i,
    input wire logic [N_SITES-1:0] site_present_xmc_i,
    input wire logic [N_TIMERS-1:0] timer_irq_i,
    input wire logic abort_irq_i,
    input wire logic temp_alert_n_i,
    input wire logic rtc_irq_n_i,
    output logic [N_RAILS-1:0] rail_en_o,
    output logic board_reset_n_o,
    output logic power_fault_o,
    output logic boot_cs_swap_o,
    output logic [N_SITES-1:0] site_mux_sel_o,
    output logic timer_abort_irq_n_o,
    output logic board_temp_irq_n_o,
    output logic rtc_irq_n_o
);
    localparam int unsigned MAX_RAILS = 32;
    localparam int unsigned N_SW = 2;
    localparam int unsigned IDX_W = (N_RAILS > 1) ? $clog2(N_RAILS) : 1;

    initial begin
        if (N_RAILS < 1 || N_RAILS > MAX_RAILS) begin
            $error("bprs_sequencer: unsupported rail count");
        end
        if (N_SITES < 1) begin
            $error("bprs_sequencer: needs at least one mezzanine site");
        end
        if (N_TIMERS < 1) begin
            $error("bprs_sequencer: needs at least one timer request");
        end
        if (DEBOUNCE_CYCLES < 1) begin
            $error("bprs_sequencer: debounce count must be at least one");
        end
        if (RAIL_WAIT_CYCLES < 1) begin
            $error("bprs_sequencer: rail wait count must be at least one");
        end
        if (RESET_CYCLES < 1) begin
            $error("bprs_sequencer: reset count must be at least one");
        end
    end

    function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c);
        cnt_step = (c == '0) ? '0 : c - 1'b1;
    endfunction

    function automatic logic [N_RAILS-1:0] rail_bit(input logic [IDX_W-1:0] k);
        rail_bit = N_RAILS'(1'b1) << k;
    endfunction

    // Switch synchronisers and debounce
    logic [N_SW-1:0] sw_meta_reg, sw_meta_next;
    logic [N_SW-1:0] sw_sync_reg, sw_sync_next;
    logic [N_SW-1:0] sw_stable_reg, sw_stable_next;
    logic [N_SW-1:0] sw_prev_reg, sw_prev_next;
    logic [CNT_W-1:0] db_cnt_reg [N_SW];
    logic [CNT_W-1:0] db_cnt_next [N_SW];
    logic sw_press;

    always_comb begin
        sw_meta_next = {~rear_reset_sw_n_i, ~front_reset_sw_n_i};
        sw_sync_next = sw_meta_reg;
        sw_stable_next = sw_stable_reg;
        sw_prev_next = sw_stable_reg;
        for (int i = 0; i < N_SW; i++) begin
            if (sw_sync_reg[i] == sw_stable_reg[i]) begin
                db_cnt_next[i] = CNT_W'(DEBOUNCE_CYCLES);
            end else if (db_cnt_reg[i] <= CNT_W'(1)) begin
                db_cnt_next[i] = CNT_W'(DEBOUNCE_CYCLES);
                sw_stable_next[i] = sw_sync_reg[i];
            end else begin
                db_cnt_next[i] = cnt_step(db_cnt_reg[i]);
            end
        end
        sw_press = |(sw_stable_reg & ~sw_prev_reg);
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            sw_meta_reg <= '0;
            sw_sync_reg <= '0;
            sw_stable_reg <= '0;
            sw_prev_reg <= '0;
            for (int i = 0; i < N_SW; i++) begin
                db_cnt_reg[i] <= CNT_W'(DEBOUNCE_CYCLES);
            end
        end else begin
            sw_meta_reg <= sw_meta_next;
            sw_sync_reg <= sw_sync_next;
            sw_stable_reg <= sw_stable_next;
            sw_prev_reg <= sw_prev_next;
            for (int i = 0; i < N_SW; i++) begin
                db_cnt_reg[i] <= db_cnt_next[i];
            end
        end
    end

    // Power and reset sequencer
    bprs_state_t state_reg, state_next;
    logic [N_RAILS-1:0] rail_en_reg, rail_en_next;
    // Rails confirmed good; only these can count as lost
    logic [N_RAILS-1:0] rail_ok_reg, rail_ok_next;
    logic [IDX_W-1:0] idx_reg, idx_next;
    logic [CNT_W-1:0] tmr_reg, tmr_next;
    logic board_reset_n_reg, board_reset_n_next;
    logic fault_reg, fault_next;
    logic boot_pending_reg, boot_pending_next;
    logic cs_swap_reg, cs_swap_next;
    logic strap_done_reg, strap_done_next;
    logic reset_req;
    logic rail_lost;

    always_comb begin
        state_next = state_reg;
        rail_en_next = rail_en_reg;
        rail_ok_next = rail_ok_reg;
        idx_next = idx_reg;
        tmr_next = cnt_step(tmr_reg);
        board_reset_n_next = board_reset_n_reg;
        fault_next = fault_reg;
        boot_pending_next = boot_pending_reg;
        cs_swap_next = cs_swap_reg;
        strap_done_next = 1'b1;
        reset_req = sw_press | cpu_reset_req_i | watchdog_reset_i;
        rail_lost = |(rail_ok_reg & ~rail_pgood_i);
        // Strap sampled once after power arrival
        if (!strap_done_reg) begin
            cs_swap_next = boot_select_switch_i;
        end
        // Confirmed boot disarms the flash fail-over
        if (board_reset_n_reg && boot_ok_i) begin
            boot_pending_next = 1'b0;
        end
        case (state_reg)
            BPRS_ST_OFF: begin
                rail_en_next = '0;
                board_reset_n_next = 1'b0;
                rail_ok_next = '0;
                idx_next = '0;
                tmr_next = CNT_W'(RAIL_WAIT_CYCLES);
                if (strap_done_reg) begin
                    state_next = BPRS_ST_RAMP;
                end
            end
            BPRS_ST_RAMP: begin
                board_reset_n_next = 1'b0;
                rail_en_next = rail_en_reg | rail_bit(idx_reg);
                if (rail_lost || (tmr_reg == '0)) begin
                    rail_en_next = '0;
                    fault_next = 1'b1;
                    state_next = BPRS_ST_FAULT;
                end else if (|(rail_pgood_i & rail_en_reg & rail_bit(idx_reg))) begin
                    rail_ok_next = rail_ok_reg | rail_bit(idx_reg);
                    tmr_next = CNT_W'(RAIL_WAIT_CYCLES);
                    if (idx_reg == IDX_W'(N_RAILS - 1)) begin
                        tmr_next = CNT_W'(RESET_CYCLES);
                        boot_pending_next = 1'b1;
                        state_next = BPRS_ST_RESET;
                    end else begin
                        idx_next = idx_reg + 1'b1;
                    end
                end
            end
            BPRS_ST_RESET: begin
                board_reset_n_next = 1'b0;
                if (rail_lost) begin
                    rail_en_next = '0;
                    fault_next = 1'b1;
                    state_next = BPRS_ST_FAULT;
                end else if (tmr_reg == '0) begin
                    board_reset_n_next = 1'b1;
                    state_next = BPRS_ST_RUN;
                end
            end
            BPRS_ST_RUN: begin
                if (rail_lost) begin
                    rail_en_next = '0;
                    board_reset_n_next = 1'b0;
                    fault_next = 1'b1;
                    state_next = BPRS_ST_FAULT;
                end else if (reset_req) begin
                    if (watchdog_reset_i && boot_pending_reg) begin
                        cs_swap_next = ~cs_swap_reg;
                    end
                    boot_pending_next = 1'b1;
                    board_reset_n_next = 1'b0;
                    tmr_next = CNT_W'(RESET_CYCLES);
                    state_next = BPRS_ST_RESET;
                end
            end
            BPRS_ST_FAULT: begin
                rail_en_next = '0;
                rail_ok_next = '0;
                board_reset_n_next = 1'b0;
                fault_next = 1'b1;
            end
            default: begin
                state_next = BPRS_ST_OFF;
            end
        endcase
    end

    // Reset only from power arrival; a latched fault ignores it
    always_ff @(posedge clk_sys_i) begin
        if (srst_i && state_reg != BPRS_ST_FAULT) begin
            state_reg <= BPRS_ST_OFF;
            rail_en_reg <= '0;
            rail_ok_reg <= '0;
            idx_reg <= '0;
            tmr_reg <= '0;
            board_reset_n_reg <= 1'b0;
            fault_reg <= 1'b0;
            boot_pending_reg <= 1'b0;
            cs_swap_reg <= 1'b0;
            strap_done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rail_en_reg <= rail_en_next;
            rail_ok_reg <= rail_ok_next;
            idx_reg <= idx_next;
            tmr_reg <= tmr_next;
            board_reset_n_reg <= board_reset_n_next;
            fault_reg <= fault_next;
            boot_pending_reg <= boot_pending_next;
            cs_swap_reg <= cs_swap_next;
            strap_done_reg <= strap_done_next;
        end
    end

    // Mezzanine mux steering from card presence
    logic [N_SITES-1:0] site_sel_reg, site_sel_next;

    always_comb begin
        for (int s = 0; s < N_SITES; s++) begin
            site_sel_next[s] = (site_present_xmc_i[s] == 1'(SITE_SEL_XMC));
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            site_sel_reg <= '0;
        end else begin
            site_sel_reg <= site_sel_next;
        end
    end

    // Interrupt forwarding toward the processor
    bprs_irq_t irq_reg, irq_next;

    always_comb begin
        irq_next.timer_abort_irq_n = ~(|timer_irq_i | abort_irq_i);
        irq_next.board_temp_irq_n = temp_alert_n_i;
        irq_next.rtc_irq_n = rtc_irq_n_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            irq_reg <= '1;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign rail_en_o = rail_en_reg;
    assign board_reset_n_o = board_reset_n_reg;
    assign power_fault_o = fault_reg;
    assign boot_cs_swap_o = cs_swap_reg;
    assign site_mux_sel_o = site_sel_reg;
    assign timer_abort_irq_n_o = irq_reg.timer_abort_irq_n;
    assign board_temp_irq_n_o = irq_reg.board_temp_irq_n;
    assign rtc_irq_n_o = irq_reg.rtc_irq_n;
endmodule
`default_nettype wire

// ---- bprs_sequencer_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t mismatch", $time); end end
module bprs_sequencer_bench;
    logic clk = 1'b0, srst = 1'b1, hold = 1'b1, front_n = 1'b1, rear_n = 1'b1, cpu_req = 1'b0, wdog = 1'b0;
    logic boot_ok = 1'b0, abort = 1'b0, temp_n = 1'b1, rtc_n = 1'b1, rst_n, fault, swap, it_n, ib_n, ir_n;
    logic boot_sw = 1'b1;
    logic [1:0] present = 2'h0, mux;
    logic [3:0] timers = 4'h0, fail = 4'h0, pgood, en;
    int n_errors = 0, comparisons = 0;
    always #25 clk = ~clk;
    bprs_rails u_rails (.clk_sys_i(clk), .hold_i(hold), .fail_i(fail), .rail_en_i(en), .rail_pgood_o(pgood));
    bprs_sequencer #(.DEBOUNCE_CYCLES(4), .RAIL_WAIT_CYCLES(20), .RESET_CYCLES(3)) DUT (
        .clk_sys_i(clk), .srst_i(srst), .rail_pgood_i(pgood), .front_reset_sw_n_i(front_n),
        .rear_reset_sw_n_i(rear_n), .cpu_reset_req_i(cpu_req), .watchdog_reset_i(wdog), .boot_ok_i(boot_ok),
        .boot_select_switch_i(boot_sw), .site_present_xmc_i(present), .timer_irq_i(timers), .abort_irq_i(abort),
        .temp_alert_n_i(temp_n), .rtc_irq_n_i(rtc_n), .rail_en_o(en), .board_reset_n_o(rst_n),
        .power_fault_o(fault), .boot_cs_swap_o(swap), .site_mux_sel_o(mux), .timer_abort_irq_n_o(it_n),
        .board_temp_irq_n_o(ib_n), .rtc_irq_n_o(ir_n));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic wait_rst(input logic v);
        for (int i = 0; i < 60 && rst_n !== v; i++) cyc(1);
    endtask
    task automatic final_report;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic t_powerup(input logic sw);
        {srst, hold, boot_sw} = {2'b11, sw};
        cyc(2);
        srst = 1'b0;
        cyc(1);
        `CHK({en, rst_n, swap}, {4'h0, 1'b0, sw})
        boot_sw = ~sw;
        cyc(7);
        `CHK({en, rst_n, swap}, {4'h1, 1'b0, sw})
        hold = 1'b0;
        wait_rst(1'b1);
        `CHK({en, rst_n}, 5'b11111)
    endtask
    task automatic t_pass;
        {present, timers, temp_n} = {2'h2, 4'h8, 1'b0};
        cyc(2);
        `CHK({mux, it_n, ib_n, ir_n}, 5'b10001)
        {present, timers, abort, temp_n, rtc_n} = {2'h1, 4'h0, 3'b110};
        cyc(2);
        `CHK({mux, it_n, ib_n, ir_n}, 5'b01010)
        {abort, rtc_n} = 2'b01;
        cyc(2);
        `CHK({it_n, ir_n}, 2'b11)
    endtask
    task automatic t_req(input int k);
        {cpu_req, front_n, rear_n} = {k == 0, k != 1, k != 2};
        wait_rst(1'b0);
        `CHK(rst_n, 1'b0)
        {cpu_req, front_n, rear_n} = 3'b011;
        wait_rst(1'b1);
        `CHK(rst_n, 1'b1)
        cyc(12);
    endtask
    task automatic t_glitch;
        logic lo;
        lo = 1'b0;
        front_n = 1'b0;
        cyc(2);
        front_n = 1'b1;
        repeat (12) begin
            cyc(1);
            lo = lo | !rst_n;
        end
        `CHK(lo, 1'b0)
    endtask
    task automatic t_wdog(input logic ok, input logic exp);
        boot_ok = ok;
        cyc(1);
        {boot_ok, wdog} = 2'b01;
        wait_rst(1'b0);
        wdog = 1'b0;
        wait_rst(1'b1);
        `CHK({rst_n, swap}, {1'b1, exp})
    endtask
    task automatic t_fault;
        fail = 4'h4;
        cyc(3);
        `CHK({en, fault, rst_n}, 6'b000010)
        {fail, srst} = 5'h01;
        cyc(2);
        {srst, cpu_req} = 2'b01;
        cyc(30);
        `CHK({en, fault, rst_n}, 6'b000010)
    endtask
    initial begin
        t_powerup(1'b1);
        t_pass;
        for (int k = 0; k < 3; k++) t_req(k);
        t_glitch;
        t_wdog(1'b0, 1'b0);
        t_wdog(1'b1, 1'b0);
        t_wdog(1'b0, 1'b1);
        t_powerup(1'b0);
        t_fault;
        final_report;
    end
    initial begin
        #400000;
        n_errors++;
        final_report;
    end
endmodule
`default_nettype wire

// ---- bprs_sequencer_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module bprs_sequencer_chk (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [3:0] rail_pgood_i,
    input wire logic cpu_reset_req_i,
    input wire logic [1:0] site_present_xmc_i,
    input wire logic [3:0] timer_irq_i,
    input wire logic abort_irq_i,
    input wire logic temp_alert_n_i,
    input wire logic rtc_irq_n_i,
    input wire logic [3:0] rail_en_o,
    input wire logic board_reset_n_o,
    input wire logic power_fault_o,
    input wire logic boot_cs_swap_o,
    input wire logic [1:0] site_mux_sel_o,
    input wire logic timer_abort_irq_n_o,
    input wire logic board_temp_irq_n_o,
    input wire logic rtc_irq_n_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    a_fault_all_off: assert property (power_fault_o |-> rail_en_o == 4'h0 && !board_reset_n_o)
        else $error("enable on in fault");
    a_rail_loss: assert property (board_reset_n_o && rail_pgood_i != 4'hf |=> power_fault_o)
        else $error("rail loss missed");
    a_fault_stays: assert property (power_fault_o |=> power_fault_o)
        else $error("fault cleared");
    a_run_needs_up: assert property (board_reset_n_o |-> rail_en_o == 4'hf && !power_fault_o)
        else $error("reset left early");
    a_rail_order: assert property (rail_en_o inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
        else $error("rail order");
    a_cpu_request: assert property (board_reset_n_o && cpu_reset_req_i |=> !board_reset_n_o)
        else $error("request ignored");
    a_pulse_len: assert property ($fell(board_reset_n_o) && !power_fault_o |-> !board_reset_n_o [*4] ##1 board_reset_n_o)
        else $error("pulse length");
    a_mux_follow: assert property (!$past(srst_i) |-> site_mux_sel_o == $past(site_present_xmc_i))
        else $error("mux select");
    a_timer_irq: assert property (!$past(srst_i) |-> timer_abort_irq_n_o == !$past(|{timer_irq_i, abort_irq_i}))
        else $error("timer irq");
    a_irq_pass: assert property (!$past(srst_i) |-> {board_temp_irq_n_o, rtc_irq_n_o} == $past({temp_alert_n_i, rtc_irq_n_i}))
        else $error("irq pass");
    c_run: cover property ($rose(board_reset_n_o));
    c_fault: cover property ($rose(power_fault_o));
    c_swap: cover property ($changed(boot_cs_swap_o));
endmodule
bind bprs_sequencer bprs_sequencer_chk u_chk (.*);
`default_nettype wire
